// *** hw/timer16_pkg.sv ***
package timer16_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on the APB
  // ---------------------------------------------------------------------------
  localparam logic [7:0] COUNT_LOW_OFS    = 8'h00;
  localparam logic [7:0] COUNT_HIGH_OFS   = 8'h04;
  localparam logic [7:0] CAPTURE_LOW_OFS  = 8'h08;
  localparam logic [7:0] CAPTURE_HIGH_OFS = 8'h0C;
  localparam logic [7:0] CONTROL_A_OFS    = 8'h10;
  localparam logic [7:0] CONTROL_B_OFS    = 8'h14;
  localparam logic [7:0] FLAGS_OFS        = 8'h18;
  localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h1C;
  localparam logic [7:0] COMP_CTRL_OFS    = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_B_CS_LSB      = 0;   // clock_source_select, 3 bits
  localparam int CTRL_B_WGM_HI_LSB  = 3;   // waveform_mode_select[3:2]
  localparam int CTRL_B_EDGE_BIT    = 6;   // capture_edge_select
  localparam int CTRL_B_FILTER_BIT  = 7;   // capture_filter_enable
  localparam int CTRL_A_WGM_LO_LSB  = 0;   // waveform_mode_select[1:0]
  localparam int FLAG_OVERFLOW_BIT  = 0;
  localparam int FLAG_CAPTURE_BIT   = 1;
  localparam int COMP_CAPTURE_BIT   = 2;   // comparator_capture_select

  // ---------------------------------------------------------------------------
  // Reset values and count constants
  // ---------------------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [2:0]  CS_STOPPED    = 3'h0;
  localparam logic [2:0]  CS_SYSCLK     = 3'h1;
  localparam int          FILTER_SAMPLES = 4;

  // ---------------------------------------------------------------------------
  // Waveform modes the counter distinguishes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] WGM_NORMAL      = 4'h0;
  localparam logic [3:0] WGM_PC_8BIT     = 4'h1;
  localparam logic [3:0] WGM_PC_9BIT     = 4'h2;
  localparam logic [3:0] WGM_PC_10BIT    = 4'h3;
  localparam logic [3:0] WGM_CTC_A       = 4'h4;
  localparam logic [3:0] WGM_FAST_8BIT   = 4'h5;
  localparam logic [3:0] WGM_FAST_9BIT   = 4'h6;
  localparam logic [3:0] WGM_FAST_10BIT  = 4'h7;
  localparam logic [3:0] WGM_PFC_CAPTURE = 4'h8;
  localparam logic [3:0] WGM_PFC_A       = 4'h9;
  localparam logic [3:0] WGM_PC_CAPTURE  = 4'hA;
  localparam logic [3:0] WGM_PC_A        = 4'hB;
  localparam logic [3:0] WGM_CTC_CAPTURE = 4'hC;
  localparam logic [3:0] WGM_FAST_CAPT   = 4'hE;

endpackage

// *** hw/capture_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module capture_filter #(
  parameter int SAMPLES = 4
) (
  input  wire logic pclk,          // System clock
  input  wire logic presetn,       // Async reset, active low
  input  wire logic sample_in,     // Synchronised capture level
  input  wire logic filter_enable, // Four-sample filter on
  input  wire logic edge_select,   // 1 rising, 0 falling
  input  wire logic detect_enable, // Edge detector armed
  output logic      capture_event  // One-cycle capture pulse
);

  logic [SAMPLES-1:0] history_r;
  logic               filtered_r;
  logic               prev_r;
  logic               all_high;
  logic               all_low;
  logic               filtered_nxt;
  logic               rise;
  logic               fall;

  assign all_high     = &history_r;
  assign all_low      = ~|history_r;
  // With the filter on, output only moves once every sample agrees; with it off it follows sample_in
  assign filtered_nxt = !filter_enable ? sample_in :
                        all_high ? 1'b1 : all_low ? 1'b0 : filtered_r;
  assign rise         = filtered_r & ~prev_r;
  assign fall         = ~filtered_r & prev_r;
  assign capture_event = detect_enable & (edge_select ? rise : fall);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      history_r  <= '0;
      filtered_r <= 1'b0;
      prev_r     <= 1'b0;
    end else begin
      history_r  <= {history_r[SAMPLES-2:0], sample_in};
      filtered_r <= filtered_nxt;
      prev_r     <= filtered_r;
    end
  end

endmodule // capture_filter

`default_nettype wire

// *** hw/timer16_capture.sv ***
`timescale 1ns/1ps
`default_nettype none

module timer16_capture #(
  parameter bit HAS_COMPARATOR = 1'b1  // Comparator capture source present
) (
  input  wire logic        pclk,              // System clock, 200 MHz
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped address
  input  wire logic        prescale_tick,     // Prescaler tick, same clock
  input  wire logic        capture_pin,       // Capture pad level, async
  input  wire logic        comparator_output, // Comparator level, async
  input  wire logic        overflow_irq_ack,  // Overflow interrupt serviced
  input  wire logic        capture_irq_ack,   // Capture interrupt serviced
  output logic             overflow_irq,      // Overflow interrupt request
  output logic             capture_irq,       // Capture interrupt request
  output logic             at_bottom,         // Count is zero
  output logic             at_max             // Count is all ones
);

  // ---------------------------------------------------------------------------
  // Mode decoding
  // ---------------------------------------------------------------------------
  function automatic logic uses_capture_top(input logic [3:0] mode);
    uses_capture_top = (mode == timer16_pkg::WGM_PFC_CAPTURE) || (mode == timer16_pkg::WGM_PC_CAPTURE) ||
                       (mode == timer16_pkg::WGM_CTC_CAPTURE) || (mode == timer16_pkg::WGM_FAST_CAPT);
  endfunction

  function automatic logic dual_slope(input logic [3:0] mode);
    dual_slope = (mode == timer16_pkg::WGM_PC_8BIT) || (mode == timer16_pkg::WGM_PC_9BIT) ||
                 (mode == timer16_pkg::WGM_PC_10BIT) || (mode == timer16_pkg::WGM_PFC_CAPTURE) ||
                 (mode == timer16_pkg::WGM_PFC_A) || (mode == timer16_pkg::WGM_PC_CAPTURE) ||
                 (mode == timer16_pkg::WGM_PC_A);
  endfunction

  function automatic logic clear_on_match(input logic [3:0] mode);
    clear_on_match = (mode == timer16_pkg::WGM_CTC_A) || (mode == timer16_pkg::WGM_CTC_CAPTURE);
  endfunction

  // Compare units are absent, so modes that take their top from them run to MAX
  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] capt);
    if (uses_capture_top(mode)) begin
      top_of = capt;
    end else if (mode == timer16_pkg::WGM_PC_8BIT || mode == timer16_pkg::WGM_FAST_8BIT) begin
      top_of = timer16_pkg::TOP_8BIT;
    end else if (mode == timer16_pkg::WGM_PC_9BIT || mode == timer16_pkg::WGM_FAST_9BIT) begin
      top_of = timer16_pkg::TOP_9BIT;
    end else if (mode == timer16_pkg::WGM_PC_10BIT || mode == timer16_pkg::WGM_FAST_10BIT) begin
      top_of = timer16_pkg::TOP_10BIT;
    end else begin
      top_of = timer16_pkg::COUNT_MAX;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] count_value_r;
  logic [15:0] count_value_nxt;
  logic [15:0] capture_value_r;
  logic [7:0]  hold_byte_r;
  logic        count_down_r;
  logic        count_down_nxt;
  logic [2:0]  clock_source_select_r;
  logic [3:0]  waveform_mode_select_r;
  logic        capture_edge_select_r;
  logic        capture_filter_enable_r;
  logic        comparator_capture_select_r;
  logic        overflow_flag_r;
  logic        capture_flag_r;
  logic        overflow_irq_enable_r;
  logic        capture_irq_enable_r;
  logic        pin_meta_r;
  logic        pin_sync_r;
  logic        comp_meta_r;
  logic        comp_sync_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        overflow_irq_r;
  logic        capture_irq_r;
  logic        at_bottom_r;
  logic        at_max_r;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic        access_first;
  logic        wr_done;
  logic        rd_take;
  logic        addr_ok;
  logic        sel_cnt_lo;
  logic        sel_cnt_hi;
  logic        sel_cap_lo;
  logic        sel_cap_hi;
  logic        sel_ctrl_a;
  logic        sel_ctrl_b;
  logic        sel_flags;
  logic        sel_irq_en;
  logic        sel_comp;
  logic [7:0]  read_byte;
  logic [7:0]  wbyte;

  // One wait state: ready rises a cycle into the access phase
  assign access_first = psel & penable & ~pready_r;
  assign wr_done      = psel & penable & pready_r & pwrite & ~pslverr_r;
  // Read side effects land on the same edge the data is sampled, keeping the pair atomic
  assign rd_take      = access_first & ~pwrite & addr_ok;
  assign wbyte        = pwdata[7:0];

  assign sel_cnt_lo = (paddr == timer16_pkg::COUNT_LOW_OFS);
  assign sel_cnt_hi = (paddr == timer16_pkg::COUNT_HIGH_OFS);
  assign sel_cap_lo = (paddr == timer16_pkg::CAPTURE_LOW_OFS);
  assign sel_cap_hi = (paddr == timer16_pkg::CAPTURE_HIGH_OFS);
  assign sel_ctrl_a = (paddr == timer16_pkg::CONTROL_A_OFS);
  assign sel_ctrl_b = (paddr == timer16_pkg::CONTROL_B_OFS);
  assign sel_flags  = (paddr == timer16_pkg::FLAGS_OFS);
  assign sel_irq_en = (paddr == timer16_pkg::IRQ_ENABLE_OFS);
  assign sel_comp   = (paddr == timer16_pkg::COMP_CTRL_OFS);
  assign addr_ok    = sel_cnt_lo | sel_cnt_hi | sel_cap_lo | sel_cap_hi | sel_ctrl_a |
                      sel_ctrl_b | sel_flags | sel_irq_en | sel_comp;

  assign read_byte = sel_cnt_lo ? count_value_r[7:0] :
                     (sel_cnt_hi || sel_cap_hi) ? hold_byte_r :
                     sel_cap_lo ? capture_value_r[7:0] :
                     sel_ctrl_a ? {6'b00_0000, waveform_mode_select_r[1:0]} :
                     sel_ctrl_b ? {capture_filter_enable_r, capture_edge_select_r, 1'b0,
                                   waveform_mode_select_r[3:2], clock_source_select_r} :
                     sel_flags  ? {6'b00_0000, capture_flag_r, overflow_flag_r} :
                     sel_irq_en ? {6'b00_0000, capture_irq_enable_r, overflow_irq_enable_r} :
                     sel_comp   ? {5'b0_0000, comparator_capture_select_r, 2'b00} : 8'h00;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  logic        tick;
  logic [15:0] top_value;
  logic        at_top;
  logic        is_dual;
  logic        count_write;
  logic        overflow_event;

  assign tick        = (clock_source_select_r == timer16_pkg::CS_SYSCLK) ? 1'b1 :
                       (clock_source_select_r == timer16_pkg::CS_STOPPED) ? 1'b0 : prescale_tick;
  assign top_value   = top_of(waveform_mode_select_r, capture_value_r);
  assign at_top      = (count_value_r == top_value);
  assign is_dual     = dual_slope(waveform_mode_select_r);
  assign count_write = wr_done & sel_cnt_lo;

  // Overflow: bottom for dual slope, MAX for clear-on-match, top otherwise
  assign overflow_event = tick & ~count_write &
                          (is_dual ? (count_down_r && count_value_r == timer16_pkg::COUNT_BOTTOM) :
                           clear_on_match(waveform_mode_select_r) ? (count_value_r == timer16_pkg::COUNT_MAX) :
                           at_top);

  always_comb begin
    count_value_nxt = count_value_r;
    count_down_nxt  = count_down_r;
    if (count_write) begin
      count_value_nxt = {hold_byte_r, wbyte};
    end else if (tick) begin
      if (is_dual) begin
        if (!count_down_r && at_top) begin
          count_down_nxt  = 1'b1;
          count_value_nxt = count_value_r - 16'h0001;
        end else if (count_down_r && count_value_r == timer16_pkg::COUNT_BOTTOM) begin
          count_down_nxt  = 1'b0;
          count_value_nxt = count_value_r + 16'h0001;
        end else if (count_down_r) begin
          count_value_nxt = count_value_r - 16'h0001;
        end else begin
          count_value_nxt = count_value_r + 16'h0001;
        end
      end else begin
        count_down_nxt  = 1'b0;
        count_value_nxt = at_top ? timer16_pkg::COUNT_RESET : count_value_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Capture path
  // ---------------------------------------------------------------------------
  logic capture_source;
  logic capture_event;
  logic capture_armed;
  logic capture_write;

  assign capture_source = (HAS_COMPARATOR && comparator_capture_select_r) ? comp_sync_r : pin_sync_r;
  assign capture_armed  = ~uses_capture_top(waveform_mode_select_r);
  assign capture_write  = wr_done & sel_cap_lo & uses_capture_top(waveform_mode_select_r);

  capture_filter #(
    .SAMPLES (timer16_pkg::FILTER_SAMPLES)
  ) u_filter (
    .pclk          (pclk),
    .presetn       (presetn),
    .sample_in     (capture_source),
    .filter_enable (capture_filter_enable_r),
    .edge_select   (capture_edge_select_r),
    .detect_enable (capture_armed),
    .capture_event (capture_event)
  );

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r  <= 1'b0;
      pin_sync_r  <= 1'b0;
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      pin_meta_r  <= capture_pin;
      pin_sync_r  <= pin_meta_r;
      comp_meta_r <= comparator_output;
      comp_sync_r <= comp_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Count, capture and holding byte
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r   <= timer16_pkg::COUNT_RESET;
      count_down_r    <= 1'b0;
      capture_value_r <= timer16_pkg::COUNT_RESET;
      hold_byte_r     <= timer16_pkg::BYTE_RESET;
    end else begin
      count_value_r <= count_value_nxt;
      count_down_r  <= count_down_nxt;
      if (capture_event) begin
        capture_value_r <= count_value_r;
      end else if (capture_write) begin
        capture_value_r <= {hold_byte_r, wbyte};
      end
      // Holding byte only changes on these accesses; otherwise it keeps its value
      if (rd_take && sel_cnt_lo) begin
        hold_byte_r <= count_value_r[15:8];
      end else if (rd_take && sel_cap_lo) begin
        hold_byte_r <= capture_value_r[15:8];
      end else if (wr_done && (sel_cnt_hi || sel_cap_hi)) begin
        hold_byte_r <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control and flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_r       <= timer16_pkg::CS_STOPPED;
      waveform_mode_select_r      <= timer16_pkg::WGM_NORMAL;
      capture_edge_select_r       <= 1'b0;
      capture_filter_enable_r     <= 1'b0;
      comparator_capture_select_r <= 1'b0;
      overflow_irq_enable_r       <= 1'b0;
      capture_irq_enable_r        <= 1'b0;
    end else if (wr_done) begin
      if (sel_ctrl_a) begin
        waveform_mode_select_r[1:0] <= wbyte[timer16_pkg::CTRL_A_WGM_LO_LSB +: 2];
      end else if (sel_ctrl_b) begin
        clock_source_select_r       <= wbyte[timer16_pkg::CTRL_B_CS_LSB +: 3];
        waveform_mode_select_r[3:2] <= wbyte[timer16_pkg::CTRL_B_WGM_HI_LSB +: 2];
        capture_edge_select_r       <= wbyte[timer16_pkg::CTRL_B_EDGE_BIT];
        capture_filter_enable_r     <= wbyte[timer16_pkg::CTRL_B_FILTER_BIT];
      end else if (sel_irq_en) begin
        overflow_irq_enable_r <= wbyte[timer16_pkg::FLAG_OVERFLOW_BIT];
        capture_irq_enable_r  <= wbyte[timer16_pkg::FLAG_CAPTURE_BIT];
      end else if (sel_comp) begin
        comparator_capture_select_r <= HAS_COMPARATOR & wbyte[timer16_pkg::COMP_CAPTURE_BIT];
      end
    end
  end

  logic overflow_clear;
  logic capture_clear;

  assign overflow_clear = overflow_irq_ack | (wr_done & sel_flags & wbyte[timer16_pkg::FLAG_OVERFLOW_BIT]);
  assign capture_clear  = capture_irq_ack | (wr_done & sel_flags & wbyte[timer16_pkg::FLAG_CAPTURE_BIT]);

  // A set in the clearing cycle wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_r <= 1'b0;
      capture_flag_r  <= 1'b0;
    end else begin
      overflow_flag_r <= overflow_event | (overflow_flag_r & ~overflow_clear);
      capture_flag_r  <= capture_event | (capture_flag_r & ~capture_clear);
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r       <= 1'b0;
      pslverr_r      <= 1'b0;
      prdata_r       <= 32'h0000_0000;
      overflow_irq_r <= 1'b0;
      capture_irq_r  <= 1'b0;
      at_bottom_r    <= 1'b1;
      at_max_r       <= 1'b0;
    end else begin
      pready_r  <= access_first;
      pslverr_r <= access_first & ~addr_ok;
      if (rd_take) begin
        prdata_r <= {24'h00_0000, read_byte};
      end
      // Request follows the flag one cycle later, gated by its enable
      overflow_irq_r <= overflow_flag_r & overflow_irq_enable_r;
      capture_irq_r  <= capture_flag_r & capture_irq_enable_r;
      at_bottom_r    <= (count_value_nxt == timer16_pkg::COUNT_BOTTOM);
      at_max_r       <= (count_value_nxt == timer16_pkg::COUNT_MAX);
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign overflow_irq = overflow_irq_r;
  assign capture_irq  = capture_irq_r;
  assign at_bottom    = at_bottom_r;
  assign at_max       = at_max_r;

endmodule // timer16_capture

`default_nettype wire

// *** tb/timer16_capture_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_sva (
  input wire logic        pclk,         // Clock
  input wire logic        presetn,      // Reset
  input wire logic        psel,         // Select
  input wire logic        penable,      // Enable
  input wire logic [31:0] prdata,       // Read data
  input wire logic        pready,       // Ready
  input wire logic        pslverr,      // Error
  input wire logic        capture_irq,  // Capture request
  input wire logic        overflow_irq, // Overflow request
  input wire logic        at_bottom,    // Zero
  input wire logic        at_max        // All ones
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_follows: assert property (psel && penable && !pready |=> pready) else $error("ready late");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside");
  a_idle_quiet: assert property (!psel |-> !pready && !pslverr) else $error("idle answer");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("wide data");
  a_ends_apart: assert property (!(at_bottom && at_max)) else $error("both ends");
  a_irq_start: assert property ($rose(presetn) |-> !capture_irq && !overflow_irq) else $error("irq");
  c_capture: cover property ($rose(capture_irq));
  c_overflow: cover property ($rose(overflow_irq));
  c_refused: cover property (pslverr);
endmodule // timer16_capture_sva
bind timer16_capture timer16_capture_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_irq(capture_irq),
  .overflow_irq(overflow_irq), .at_bottom(at_bottom), .at_max(at_max));
`default_nettype wire

// *** tb/event_pin.sv ***
`timescale 1ns/1ps
`default_nettype none
module event_pin (
  input  wire logic       pclk,  // Clock
  input  wire logic       go,    // Start pulse
  input  wire logic [3:0] width, // Pulse cycles
  output logic            pin    // Pad level
);
  logic [3:0] left_r = 4'h0;
  always_ff @(posedge pclk) begin
    if (go) left_r <= width;
    else if (left_r != 4'h0) left_r <= left_r - 4'h1;
  end
  assign pin = (left_r != 4'h0);
endmodule // event_pin
`default_nettype wire

// *** tb/test_timer16_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_timer16_capture;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack = 0, go = 0, comp = 0, pin, err;
  logic [7:0] paddr = 8'h00, q;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, ovf_irq, cap_irq, at_bottom, at_max;
  logic [3:0] width = 4'h0;
  logic [15:0] rnd = 16'h001b, v;
  int n_fail = 0, total_checks = 0;
  always #2.5 pclk = ~pclk;
  event_pin i_event_pin (.pclk(pclk), .go(go), .width(width), .pin(pin));
  timer16_capture i_timer16_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prescale_tick(1'b0),
    .capture_pin(pin), .comparator_output(comp), .overflow_irq_ack(1'b0), .capture_irq_ack(ack),
    .overflow_irq(ovf_irq), .capture_irq(cap_irq), .at_bottom(at_bottom), .at_max(at_max));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    q = prdata[7:0];
    err = pslverr;
    if (k >= 20) begin n_fail++; finish_test(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Bounded wait for one request line; a timeout counts a fail and ends the test
  task automatic wirq(input logic o);
    int k;
    for (k = 0; k < 200 && (o ? ovf_irq : cap_irq) !== 1'b1; k++) @(posedge pclk);
    if (k >= 200) begin n_fail++; finish_test(); end
  endtask
  task automatic pulse(input logic [3:0] n);
    @(posedge pclk); go <= 1'b1; width <= n;
    @(posedge pclk); go <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0); `CHK(q, 8'h00)
    `CHK(at_bottom, 1'b1)
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd); v = (i == 0) ? 16'hffff : rnd;
      apb(1, 8'h04, v[15:8]); apb(1, 8'h00, v[7:0]);
      apb(0, 8'h00, 0); `CHK(q, v[7:0])
      apb(0, 8'h04, 0); `CHK(q, v[15:8])
      `CHK(at_max, v == 16'hffff)
      `CHK(at_bottom, v == 16'h0000)
    end
    $display("test count_access done");
    apb(1, 8'h14, 8'h18); apb(1, 8'h04, 8'h5a); apb(1, 8'h08, 8'h33); apb(1, 8'h00, 8'h44);
    apb(0, 8'h08, 0); `CHK(q, 8'h33)
    apb(0, 8'h0c, 0); `CHK(q, 8'h5a)
    apb(0, 8'h00, 0); `CHK(q, 8'h44)
    $display("test shared_high done");
    apb(1, 8'h14, 8'h40); apb(1, 8'h1c, 8'h03);
    rnd = lfsr(rnd); v = rnd;
    apb(1, 8'h04, v[15:8]); apb(1, 8'h00, v[7:0]);
    pulse(4'h6); wirq(0); `CHK(cap_irq, 1'b1)
    apb(0, 8'h08, 0); `CHK(q, v[7:0])
    apb(0, 8'h0c, 0); `CHK(q, v[15:8])
    apb(0, 8'h18, 0); `CHK(q[1], 1'b1)
    apb(1, 8'h14, 8'h00);
    apb(1, 8'h18, 8'h02); apb(0, 8'h18, 0); `CHK(q[1], 1'b0)
    $display("test capture done");
    apb(1, 8'h14, 8'hc0); pulse(4'h2);
    repeat (20) @(posedge pclk); `CHK(cap_irq, 1'b0)
    pulse(4'h8); wirq(0); `CHK(cap_irq, 1'b1)
    @(posedge pclk); ack <= 1'b1;
    @(posedge pclk); ack <= 1'b0;
    repeat (20) @(posedge pclk); `CHK(cap_irq, 1'b0)
    $display("test filter done");
    apb(1, 8'h14, 8'h40); apb(1, 8'h20, 8'h04);
    apb(1, 8'h18, 8'h02);
    apb(0, 8'h20, 0); `CHK(q, 8'h04)
    pulse(4'h6);
    repeat (12) @(posedge pclk); `CHK(cap_irq, 1'b0)
    @(posedge pclk); comp <= 1'b1;
    wirq(0); `CHK(cap_irq, 1'b1)
    $display("test comparator done");
    apb(1, 8'h04, 8'hff); apb(1, 8'h00, 8'hfe); apb(1, 8'h14, 8'h01);
    wirq(1); `CHK(ovf_irq, 1'b1)
    apb(0, 8'h24, 0); `CHK(err, 1'b1)
    $display("test overflow_unmapped done");
    finish_test();
  end
endmodule // test_timer16_capture
`default_nettype wire
